//--- qmsw_pkg.sv
// Shared constants for the quad-lane flash link, device and host ends
// Contract
// - Host sets write latch before every erase
// - Erase uses four lines unless boost raised
// - Boost with accel enabled falls back single-line
// - Small erase only in eight boot sectors
// - Boost cycles poll single-line until boost low
// - Register commands same, just four lanes
// - Active while selected or cycle running
// - Line three is pure data when selected
// - Reset via line three while deselected
// - Late boost: normal speed, flag bit three
// - Working config loads from nonvolatile at boot
// - Volatile config writes apply immediately
// - Config and flag registers in every protocol
// - Busy bit set during any internal cycle
// - Cleared latch rejects writes, program, erase; volatile and enhanced config writes are taken here with the latch cleared
// - Guard bits protect region, locked when protected
// - Whole erase only with guard bits zero
// - Origin bit zero top, one bottom
// - Host sets latch before status write
// - Lock bit and low protect pin lock status
package qmsw_pkg;
	localparam logic [7:0] WRITE_LATCH_SET_CMD = 8'h06;
	localparam logic [7:0] STATUS_READ_CMD = 8'h05;
	localparam logic [7:0] STATUS_WRITE_CMD = 8'h01;
	localparam logic [7:0] SMALL_BLOCK_ERASE_CMD = 8'h20;
	localparam logic [7:0] BLOCK_ERASE_CMD = 8'hD8;
	localparam logic [7:0] WHOLE_ARRAY_ERASE_CMD = 8'hC7;
	localparam logic [7:0] PAGE_PROGRAM_CMD = 8'h02;
	localparam logic [7:0] FLAG_STATUS_READ_CMD = 8'h70;
	localparam logic [7:0] FLAG_STATUS_CLEAR_CMD = 8'h50;
	localparam logic [7:0] VOLATILE_CONFIG_WRITE_CMD = 8'h81;
	localparam logic [7:0] VOLATILE_CONFIG_READ_CMD = 8'h85;
	localparam logic [7:0] ENHANCED_CONFIG_WRITE_CMD = 8'h61;
	localparam logic [7:0] ENHANCED_CONFIG_READ_CMD = 8'h65;
	localparam logic [7:0] NONVOLATILE_CONFIG_WRITE_CMD = 8'hB1;
	localparam logic [7:0] NONVOLATILE_CONFIG_READ_CMD = 8'hB5;
	// Status layout
	localparam int SR_BUSY = 0;
	localparam int SR_LATCH = 1;
	localparam int SR_GUARD_LO = 2;
	localparam int SR_ORIGIN = 5;
	localparam int SR_GUARD3 = 6;
	localparam int SR_LOCK = 7;
	localparam logic [7:0] SR_RESET = 8'h00;
	// Config and flag layout
	localparam int ECFG_ACCEL_N = 3;
	localparam int ECFG_QUAD_N = 7;
	localparam int NV_QUAD_N = 3;
	localparam int FLAG_READY = 7;
	localparam int FLAG_BOOST_ERR = 3;
	localparam logic [15:0] NVCFG_RESET = 16'hFFFF;
	localparam logic [7:0] VCFG_RESET = 8'hFB;
	localparam logic [7:0] ECFG_RESET = 8'hDF;
	// Array geometry, in 64 KiB sectors
	localparam logic [8:0] SECTOR_COUNT = 9'h100;
	localparam logic [7:0] BOOT_SECTORS = 8'h08;
	// Timing
	localparam int CLK_HZ = 20_000_000;
	localparam int BOOST_WINDOW_MS = 200;
	localparam int BOOST_WINDOW_CYC = BOOST_WINDOW_MS * (CLK_HZ / 1000);
	localparam int TIMER_W = 23;
	localparam logic [22:0] STATUS_WRITE_CYC = 23'h000040;
	localparam logic [22:0] NVCFG_WRITE_CYC = 23'h000100;
	localparam logic [22:0] SMALL_ERASE_CYC = 23'h000100;
	localparam logic [22:0] BLOCK_ERASE_CYC = 23'h000200;
	localparam logic [22:0] ARRAY_ERASE_CYC = 23'h000400;
	localparam logic [22:0] PROG_FAST_CYC = 23'h000080;
	localparam logic [22:0] PROG_SLOW_CYC = 23'h000100;
	localparam logic [2:0] SCK_HALF_CYC = 3'h7;
	// Host register map, byte offsets
	localparam logic [7:0] HOST_CTRL_OFS = 8'h00;
	localparam logic [7:0] HOST_ADDR_OFS = 8'h04;
	localparam logic [7:0] HOST_TXD_OFS = 8'h08;
	localparam logic [7:0] HOST_CMD_OFS = 8'h0C;
	localparam logic [7:0] HOST_STAT_OFS = 8'h10;
	localparam logic [7:0] HOST_RXD_OFS = 8'h14;
	localparam int CTRL_QUAD = 0;
	localparam int CTRL_ACCEL = 1;
	localparam int CTRL_WP_N = 2;
	localparam int CTRL_BOOST = 3;
	localparam int CTRL_RESET_PIN = 4;
	localparam logic [4:0] CTRL_RESET = 5'h04;
	localparam int CMD_ADDR = 8;
	localparam int CMD_NTX = 9;
	localparam int CMD_NRX = 11;
	localparam int CMD_AUTO_LATCH = 13;
	typedef enum logic [1:0] {DEV_IDLE, DEV_BOOST_WAIT, DEV_CYCLE} qmsw_op_t;
	typedef enum logic [1:0] {H_IDLE, H_SEL, H_SHIFT, H_GAP} qmsw_host_t;
endpackage

//--- qmsw_link_if.sv
// Serial link between host controller and flash device
`timescale 1ns/100ps
interface qmsw_link_if;
	logic cs_n;
	logic sck;
	logic wp_n;
	logic boost_high;
	logic [3:0] host_dq_o;
	logic [3:0] host_dq_oe;
	logic [3:0] dev_dq_o;
	logic [3:0] dev_dq_oe;
	logic [3:0] dq;
	// Host wins a clash; an undriven line floats high
	assign dq = (host_dq_oe & host_dq_o)
		| (~host_dq_oe & dev_dq_oe & dev_dq_o) | (~host_dq_oe & ~dev_dq_oe);
	modport host (output cs_n, sck, wp_n, boost_high, host_dq_o, host_dq_oe,
		input dq);
	modport device (input cs_n, sck, wp_n, boost_high, dq,
		output dev_dq_o, dev_dq_oe);
endinterface

//--- qmsw_device.sv
// Flash device end: status, config registers, erase and write protection
//
// Decided for this implementation: the register addresses and register access over Wishbone.
`timescale 1ns/100ps
module qmsw_device import qmsw_pkg::*; #(
	parameter int BOOST_WINDOW = BOOST_WINDOW_CYC,
	parameter bit RESET_VARIANT = 1'b1,
	parameter bit BOOT_BOTTOM = 1'b1,
	parameter bit UNIFORM = 1'b0
) (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// Serial link
	qmsw_link_if.device LINK,
	// Device state
	output logic ACTIVE,
	output logic BUSY,
	output logic QUAD_MODE,
	output logic SINGLE_FALLBACK,
	output logic [7:0] STATUS,
	output logic [7:0] FLAGS
);
	localparam logic [7:0] PIN_IDLE = 8'hAF;

	logic [7:0] pin_s1, pin_s2;
	logic sck_d, cs_d;
	logic cs_n_s, sck_s, wp_n_s, boost_s;
	logic [3:0] dq_s;
	logic sck_rise, sck_fall, cs_rise;
	logic lane4, fallback, hw_prot, soft_rst;
	logic [2:0] bit_cnt, byte_cnt;
	logic [7:0] in_sr, byte_now, opcode;
	logic byte_done;
	logic [23:0] acc;
	logic [15:0] rd_sr, rd_val;
	logic rd_on;
	logic [3:0] dq_o, dq_oe;
	logic [7:2] sr_nv;
	logic write_latch_flag, busy, boost_err, boot;
	logic [15:0] nvcfg;
	logic [7:0] vcfg, ecfg, status_val, flag_val;
	logic work_quad_n, work_accel_n;
	qmsw_op_t op_state;
	logic [TIMER_W-1:0] timer, dur;
	logic exec, sr_ok, er_ok, pg_ok, nv_ok, start, guarded, op_done;
	logic [3:0] guard;

	function automatic logic in_guard(input logic [7:0] sec,
		input logic [3:0] bp, input logic org);
		logic [8:0] size;
		size = 9'h000;
		if (bp != 4'h0)
			size = (bp > 4'h8) ? SECTOR_COUNT : 9'(9'h001 << (bp - 4'h1));
		if (org)
			in_guard = {1'b0, sec} < size;
		else
			in_guard = {1'b0, sec} >= (SECTOR_COUNT - size);
	endfunction

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			pin_s1 <= PIN_IDLE;
			pin_s2 <= PIN_IDLE;
			sck_d <= 1'b0;
			cs_d <= 1'b1;
		end else begin
			pin_s1 <= {LINK.cs_n, LINK.sck, LINK.wp_n, LINK.boost_high, LINK.dq};
			pin_s2 <= pin_s1;
			sck_d <= sck_s;
			cs_d <= cs_n_s;
		end
	end

	assign {cs_n_s, sck_s, wp_n_s, boost_s, dq_s} = pin_s2;
	assign sck_rise = sck_s & ~sck_d;
	assign sck_fall = ~sck_s & sck_d;
	assign cs_rise = cs_n_s & ~cs_d;
	assign fallback = ~work_accel_n & boost_s;
	assign lane4 = ~work_quad_n & ~fallback;
	assign hw_prot = sr_nv[SR_LOCK] & ~wp_n_s;
	// Line three only resets while deselected; selected it is plain data
	assign soft_rst = RESET_VARIANT & cs_n_s & ~dq_s[3];
	assign byte_now = lane4 ? {in_sr[3:0], dq_s} : {in_sr[6:0], dq_s[0]};
	assign byte_done = lane4 ? (bit_cnt == 3'h4) : (bit_cnt == 3'h7);
	assign guard = {sr_nv[SR_GUARD3], sr_nv[SR_GUARD_LO+2:SR_GUARD_LO]};
	assign guarded = in_guard(acc[23:16], guard, sr_nv[SR_ORIGIN]);

	// Command decode; everything that changes state waits for deselect
	assign exec = cs_rise & ~soft_rst;
	assign sr_ok = exec & write_latch_flag & ~busy & ~hw_prot
		& opcode == STATUS_WRITE_CMD & byte_cnt >= 3'h2;
	assign nv_ok = exec & write_latch_flag & ~busy
		& opcode == NONVOLATILE_CONFIG_WRITE_CMD & byte_cnt >= 3'h3;
	assign pg_ok = exec & write_latch_flag & ~busy & ~guarded
		& opcode == PAGE_PROGRAM_CMD & byte_cnt >= 3'h5;
	always_comb begin
		er_ok = 1'b0;
		dur = STATUS_WRITE_CYC;
		if (exec & write_latch_flag & ~busy) begin
			case (opcode)
				SMALL_BLOCK_ERASE_CMD: begin
					er_ok = byte_cnt >= 3'h4 & ~guarded & ~UNIFORM
						& (BOOT_BOTTOM ? acc[23:16] < BOOT_SECTORS
						: acc[23:16] >= 8'(SECTOR_COUNT - 9'(BOOT_SECTORS)));
					dur = SMALL_ERASE_CYC;
				end
				BLOCK_ERASE_CMD: begin
					er_ok = byte_cnt >= 3'h4 & ~guarded;
					dur = BLOCK_ERASE_CYC;
				end
				WHOLE_ARRAY_ERASE_CMD: begin
					er_ok = guard == 4'h0;
					dur = ARRAY_ERASE_CYC;
				end
				NONVOLATILE_CONFIG_WRITE_CMD: dur = NVCFG_WRITE_CYC;
				PAGE_PROGRAM_CMD: dur = PROG_SLOW_CYC;
				default: dur = STATUS_WRITE_CYC;
			endcase
		end
	end
	assign start = sr_ok | er_ok | pg_ok | nv_ok;

	// Incoming bits, one or four per rising clock
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			bit_cnt <= 3'h0;
			byte_cnt <= 3'h0;
			in_sr <= 8'h00;
			opcode <= 8'h00;
			acc <= 24'h000000;
		end else if (cs_n_s) begin
			bit_cnt <= 3'h0;
			byte_cnt <= 3'h0;
		end else if (sck_rise) begin
			in_sr <= byte_now;
			bit_cnt <= bit_cnt + (lane4 ? 3'h4 : 3'h1);
			if (byte_done) begin
				if (byte_cnt == 3'h0)
					opcode <= byte_now;
				else
					acc <= {acc[15:0], byte_now};
				if (byte_cnt != 3'h7)
					byte_cnt <= byte_cnt + 3'h1;
			end
		end
	end

	always_comb begin
		status_val = {sr_nv, write_latch_flag, busy};
		flag_val = 8'h00;
		flag_val[FLAG_READY] = ~busy;
		flag_val[FLAG_BOOST_ERR] = boost_err;
		case (byte_now)
			STATUS_READ_CMD: rd_val = {status_val, 8'h00};
			FLAG_STATUS_READ_CMD: rd_val = {flag_val, 8'h00};
			VOLATILE_CONFIG_READ_CMD: rd_val = {vcfg, 8'h00};
			ENHANCED_CONFIG_READ_CMD: rd_val = {ecfg, 8'h00};
			NONVOLATILE_CONFIG_READ_CMD: rd_val = {nvcfg[7:0], nvcfg[15:8]};
			default: rd_val = 16'h0000;
		endcase
	end

	// Read answers: same as single-line, only the lane count differs
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			rd_on <= 1'b0;
			rd_sr <= 16'h0000;
			dq_o <= 4'h0;
			dq_oe <= 4'h0;
		end else if (cs_n_s) begin
			rd_on <= 1'b0;
			dq_oe <= 4'h0;
		end else if (sck_rise && byte_done && byte_cnt == 3'h0) begin
			rd_sr <= rd_val;
			rd_on <= rd_val != 16'h0000 || byte_now == STATUS_READ_CMD
				|| byte_now == FLAG_STATUS_READ_CMD
				|| byte_now == VOLATILE_CONFIG_READ_CMD
				|| byte_now == ENHANCED_CONFIG_READ_CMD
				|| byte_now == NONVOLATILE_CONFIG_READ_CMD;
		end else if (sck_fall && rd_on) begin
			if (lane4) begin
				dq_o <= rd_sr[15:12];
				dq_oe <= 4'hF;
				rd_sr <= {rd_sr[11:0], 4'h0};
			end else begin
				dq_o <= {2'b00, rd_sr[15], 1'b0};
				dq_oe <= 4'h2;
				rd_sr <= {rd_sr[14:0], 1'b0};
			end
		end
	end
	assign LINK.dev_dq_o = dq_o;
	assign LINK.dev_dq_oe = dq_oe;

	// Register writes and working configuration
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			sr_nv <= SR_RESET[7:2];
			write_latch_flag <= 1'b0;
			nvcfg <= NVCFG_RESET;
			vcfg <= VCFG_RESET;
			ecfg <= ECFG_RESET;
			boot <= 1'b1;
			work_quad_n <= 1'b1;
			work_accel_n <= 1'b1;
		end else if (soft_rst) begin
			write_latch_flag <= 1'b0;
			boot <= 1'b1;
		end else if (boot) begin
			work_quad_n <= nvcfg[NV_QUAD_N];
			work_accel_n <= 1'b1;
			vcfg <= VCFG_RESET;
			ecfg <= ECFG_RESET;
			boot <= 1'b0;
		end else begin
			if (exec && opcode == WRITE_LATCH_SET_CMD)
				write_latch_flag <= 1'b1;
			else if (op_done)
				write_latch_flag <= 1'b0;
			if (sr_ok)
				sr_nv <= acc[7:2];
			if (nv_ok)
				nvcfg <= {acc[7:0], acc[15:8]};
			if (exec && byte_cnt >= 3'h2 && opcode == VOLATILE_CONFIG_WRITE_CMD)
				vcfg <= acc[7:0];
			if (exec && byte_cnt >= 3'h2 && opcode == ENHANCED_CONFIG_WRITE_CMD) begin
				ecfg <= acc[7:0];
				work_quad_n <= acc[ECFG_QUAD_N];
				work_accel_n <= acc[ECFG_ACCEL_N];
			end
		end
	end

	// Internal cycle timer; boost wait holds the program start
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			op_state <= DEV_IDLE;
			timer <= '0;
			busy <= 1'b0;
			op_done <= 1'b0;
			boost_err <= 1'b0;
		end else begin
			op_done <= 1'b0;
			if (exec && opcode == FLAG_STATUS_CLEAR_CMD)
				boost_err <= 1'b0;
			case (op_state)
				DEV_IDLE: if (start) begin
					busy <= 1'b1;
					timer <= dur;
					op_state <= DEV_CYCLE;
					if (pg_ok && !work_accel_n) begin
						timer <= TIMER_W'(BOOST_WINDOW);
						op_state <= DEV_BOOST_WAIT;
					end
				end
				DEV_BOOST_WAIT: if (boost_s) begin
					timer <= PROG_FAST_CYC;
					op_state <= DEV_CYCLE;
				end else if (timer == TIMER_W'(1)) begin
					boost_err <= 1'b1;
					timer <= PROG_SLOW_CYC;
					op_state <= DEV_CYCLE;
				end else begin
					timer <= timer - TIMER_W'(1);
				end
				DEV_CYCLE: if (timer == TIMER_W'(1)) begin
					busy <= 1'b0;
					op_done <= 1'b1;
					op_state <= DEV_IDLE;
				end else begin
					timer <= timer - TIMER_W'(1);
				end
				default: op_state <= DEV_IDLE;
			endcase
			if (soft_rst) begin
				busy <= 1'b0;
				op_state <= DEV_IDLE;
			end
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			ACTIVE <= 1'b0;
			BUSY <= 1'b0;
			QUAD_MODE <= 1'b0;
			SINGLE_FALLBACK <= 1'b0;
			STATUS <= 8'h00;
			FLAGS <= 8'h00;
		end else begin
			ACTIVE <= ~cs_n_s | busy;
			BUSY <= busy;
			QUAD_MODE <= ~work_quad_n;
			SINGLE_FALLBACK <= fallback;
			STATUS <= status_val;
			FLAGS <= flag_val;
		end
	end
endmodule

//--- qmsw_host.sv
// Host controller end: Wishbone registers driving the serial link
`timescale 1ns/100ps
module qmsw_host import qmsw_pkg::*; (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// Wishbone slave
	input wire logic WB_CYC_I,
	input wire logic WB_STB_I,
	input wire logic WB_WE_I,
	input wire logic [7:0] WB_ADR_I,
	input wire logic [3:0] WB_SEL_I,
	input wire logic [31:0] WB_DAT_I,
	output logic [31:0] WB_DAT_O,
	output logic WB_ACK_O,
	// Serial link
	qmsw_link_if.host LINK
);
	logic [4:0] ctrl;
	logic [23:0] addr;
	logic [15:0] txd, rxd;
	logic [13:0] cmd;
	logic go, busy, done, write_latch_set_cmd_pend, lane4, wr, tick, sent;
	logic [3:0] dq_s1, dq_s2, dq_o, dq_oe;
	logic [2:0] div;
	logic [55:0] sr, nsr, frame;
	logic [5:0] txl, w6, frame_bits;
	logic [4:0] rxl;
	logic cs_n, sck;
	qmsw_host_t state;

	assign wr = WB_CYC_I & WB_STB_I & WB_WE_I & ~WB_ACK_O;
	assign lane4 = ctrl[CTRL_QUAD] & ~(ctrl[CTRL_ACCEL] & ctrl[CTRL_BOOST]);
	assign w6 = lane4 ? 6'h04 : 6'h01;
	assign nsr = lane4 ? {sr[51:0], 4'h0} : {sr[54:0], 1'b0};
	assign frame = {cmd[7:0], cmd[CMD_ADDR] ? {addr, txd, 8'h00} : {txd, 32'h0}};
	assign frame_bits = 6'h08 + (cmd[CMD_ADDR] ? 6'h18 : 6'h00)
		+ {1'b0, cmd[CMD_NTX+1:CMD_NTX], 3'h0};
	assign tick = div == SCK_HALF_CYC;

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			WB_ACK_O <= 1'b0;
			WB_DAT_O <= 32'h00000000;
			ctrl <= CTRL_RESET;
			addr <= 24'h000000;
			txd <= 16'h0000;
			cmd <= 14'h0000;
			go <= 1'b0;
		end else begin
			WB_ACK_O <= WB_CYC_I & WB_STB_I & ~WB_ACK_O;
			go <= 1'b0;
			WB_DAT_O <= 32'h00000000;
			case (WB_ADR_I)
				HOST_CTRL_OFS: WB_DAT_O <= {27'h0, ctrl};
				HOST_ADDR_OFS: WB_DAT_O <= {8'h00, addr};
				HOST_TXD_OFS: WB_DAT_O <= {16'h0000, txd};
				HOST_CMD_OFS: WB_DAT_O <= {18'h00000, cmd};
				HOST_STAT_OFS: WB_DAT_O <= {30'h0, done, busy};
				HOST_RXD_OFS: WB_DAT_O <= {16'h0000, rxd};
				default: WB_DAT_O <= 32'h00000000;
			endcase
			if (wr && WB_SEL_I[0] && WB_ADR_I == HOST_CTRL_OFS)
				ctrl <= WB_DAT_I[4:0];
			if (wr && WB_ADR_I == HOST_ADDR_OFS && !busy)
				addr <= WB_DAT_I[23:0];
			if (wr && WB_ADR_I == HOST_TXD_OFS && !busy)
				txd <= WB_DAT_I[15:0];
			if (wr && WB_ADR_I == HOST_CMD_OFS && !busy && !go) begin
				cmd <= WB_DAT_I[13:0];
				go <= 1'b1;
			end
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			dq_s1 <= 4'hF;
			dq_s2 <= 4'hF;
		end else begin
			dq_s1 <= LINK.dq;
			dq_s2 <= dq_s1;
		end
	end

	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N) begin
			state <= H_IDLE;
			div <= 3'h0;
			busy <= 1'b0;
			done <= 1'b0;
			write_latch_set_cmd_pend <= 1'b0;
			sent <= 1'b0;
			cs_n <= 1'b1;
			sck <= 1'b0;
			sr <= 56'h0;
			txl <= 6'h00;
			rxl <= 5'h00;
			rxd <= 16'h0000;
			dq_o <= 4'h8;
			dq_oe <= 4'h8;
		end else begin
			div <= (tick || state == H_IDLE) ? 3'h0 : div + 3'h1;
			case (state)
				H_IDLE: begin
					// Line three held as reset only while deselected
					dq_o <= {~ctrl[CTRL_RESET_PIN], 3'h0};
					if (go) begin
						busy <= 1'b1;
						done <= 1'b0;
						rxd <= 16'h0000;
						sent <= 1'b0;
						// Latch set goes first for erase, page program and status writes
						write_latch_set_cmd_pend <= cmd[CMD_AUTO_LATCH]
							& (cmd[7:0] == STATUS_WRITE_CMD
							| cmd[7:0] == SMALL_BLOCK_ERASE_CMD
							| cmd[7:0] == BLOCK_ERASE_CMD
							| cmd[7:0] == WHOLE_ARRAY_ERASE_CMD
							| cmd[7:0] == PAGE_PROGRAM_CMD);
						state <= H_GAP;
					end
				end
				H_SEL: if (tick)
					state <= H_SHIFT;
				H_SHIFT: if (tick) begin
					sck <= ~sck;
					if (!sck) begin
						if (txl != 6'h00)
							txl <= txl - w6;
						else if (rxl != 5'h00) begin
							rxl <= rxl - w6[4:0];
							rxd <= lane4 ? {rxd[11:0], dq_s2}
								: {rxd[14:0], dq_s2[1]};
						end
					end else if (txl == 6'h00 && rxl == 5'h00) begin
						cs_n <= 1'b1;
						dq_o <= 4'h8;
						dq_oe <= 4'h8;
						state <= H_GAP;
					end else if (txl != 6'h00) begin
						sr <= nsr;
						dq_o <= lane4 ? nsr[55:52] : {3'h4, nsr[55]};
					end else begin
						// Quad releases all lines; single keeps line three high
						dq_oe <= lane4 ? 4'h0 : 4'h8;
					end
				end
				H_GAP: if (tick) begin
					if (!busy) begin
						state <= H_IDLE;
					end else if (write_latch_set_cmd_pend || txl != 6'h00 || rxl != 5'h00
						|| !sent) begin
						// A frame whose tail is all zero must not be resent
						write_latch_set_cmd_pend <= 1'b0;
						sent <= sent | ~write_latch_set_cmd_pend;
						cs_n <= 1'b0;
						sr <= write_latch_set_cmd_pend ? {WRITE_LATCH_SET_CMD, 48'h0} : frame;
						txl <= write_latch_set_cmd_pend ? 6'h08 : frame_bits;
						rxl <= write_latch_set_cmd_pend ? 5'h00
							: {cmd[CMD_NRX+1:CMD_NRX], 3'h0};
						dq_o <= lane4 ? (write_latch_set_cmd_pend ? WRITE_LATCH_SET_CMD[7:4]
							: frame[55:52])
							: {3'h4, write_latch_set_cmd_pend ? 1'b0 : frame[55]};
						dq_oe <= lane4 ? 4'hF : 4'h9;
						state <= H_SEL;
					end else begin
						busy <= 1'b0;
						done <= 1'b1;
						sr <= 56'h0;
						state <= H_IDLE;
					end
				end
				default: state <= H_IDLE;
			endcase
		end
	end

	assign LINK.cs_n = cs_n;
	assign LINK.sck = sck;
	assign LINK.host_dq_o = dq_o;
	assign LINK.host_dq_oe = dq_oe;
	assign LINK.wp_n = ctrl[CTRL_WP_N];
	assign LINK.boost_high = ctrl[CTRL_BOOST];
endmodule

//--- qmsw_link_monitor.sv
// Checker beside the link that joins host and device
`timescale 1ns/100ps
module qmsw_link_monitor import qmsw_pkg::*; (
	// Clock and reset
	input wire logic MCLK,
	input wire logic RST_N,
	// Link
	input wire logic cs_n,
	input wire logic wp_n,
	input wire logic boost_high,
	input wire logic [3:0] dev_dq_oe,
	// Device state
	input wire logic ACTIVE,
	input wire logic BUSY,
	input wire logic QUAD_MODE,
	input wire logic SINGLE_FALLBACK,
	input wire logic [7:0] STATUS
);
	logic [7:0] wp_low_reg;
	logic [10:0] busy_len_reg;
	// Whole-array erase is the longest cycle; margin covers the boost wait
	localparam logic [10:0] BUSY_MAX = 11'h578;
	default clocking mon_cb @(posedge MCLK);
	endclocking
	default disable iff (!RST_N);
	// Saturates, so a long-held pin is told from one that just fell
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N)
			wp_low_reg <= 8'h00;
		else if (wp_n)
			wp_low_reg <= 8'h00;
		else if (wp_low_reg != 8'hFF)
			wp_low_reg <= wp_low_reg + 8'h01;
	end
	// Counted rather than a long delay range, which tools unroll
	always_ff @(posedge MCLK or negedge RST_N) begin
		if (!RST_N)
			busy_len_reg <= 11'h000;
		else if (!BUSY)
			busy_len_reg <= 11'h000;
		else if (busy_len_reg != 11'h7FF)
			busy_len_reg <= busy_len_reg + 11'h001;
	end
	sequence busy_run;
		BUSY [*8];
	endsequence
	a_active_selected: assert property (!cs_n [*8] |-> ACTIVE)
		else $error("device idle while selected");
	a_active_busy: assert property (BUSY [*2] |-> ACTIVE)
		else $error("device idle during a cycle");
	a_busy_status: assert property ($rose(BUSY) |-> ##[0:2] STATUS[SR_BUSY])
		else $error("busy bit missing");
	a_busy_span: assert property ($rose(BUSY) |-> busy_run)
		else $error("cycle length out of range");
	a_busy_bound: assert property (busy_len_reg <= BUSY_MAX)
		else $error("cycle runs too long");
	a_latch_guard: assert property ($changed(STATUS[6:2]) |-> $past(STATUS[SR_LATCH]))
		else $error("guard bits changed without latch");
	a_lock_freeze: assert property (wp_low_reg == 8'hFF && STATUS[SR_LOCK]
		|=> $stable(STATUS[6:2]))
		else $error("guard bits changed while locked");
	a_single_lanes: assert property (!QUAD_MODE && dev_dq_oe != 4'h0
		|-> dev_dq_oe == 4'h2)
		else $error("single mode drove wrong lanes");
	a_quad_lanes: assert property (QUAD_MODE && !SINGLE_FALLBACK
		&& dev_dq_oe != 4'h0 |-> dev_dq_oe == 4'hF)
		else $error("quad mode drove wrong lanes");
	a_fallback_lanes: assert property (SINGLE_FALLBACK && dev_dq_oe != 4'h0
		|-> dev_dq_oe == 4'h2)
		else $error("fallback drove wrong lanes");
	a_fallback_ends: assert property (!boost_high [*8] |-> !SINGLE_FALLBACK)
		else $error("fallback kept with boost low");
endmodule

//--- qmsw_test.sv
// Self-checking bench: host and device joined over the link
`timescale 1ns/100ps
module qmsw_test import qmsw_pkg::*;;
	logic mclk = 1'b0;
	logic rst_n = 1'b0;
	logic cyc = 1'b0;
	logic stb = 1'b0;
	logic we = 1'b0;
	logic [7:0] adr = 8'h00;
	logic [31:0] wdat = 32'h0;
	logic [31:0] rdat;
	logic ack, active, busy, quad, fallback;
	logic [7:0] status, flags;
	int bad_count = 0;
	int samples_checked = 0;
	qmsw_link_if link ();
	always #25 mclk = ~mclk;
	qmsw_host qmsw_host_i (.MCLK(mclk), .RST_N(rst_n), .WB_CYC_I(cyc),
		.WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(4'hF),
		.WB_DAT_I(wdat), .WB_DAT_O(rdat), .WB_ACK_O(ack), .LINK(link));
	// Short boost window keeps the late-boost case quick
	qmsw_device #(.BOOST_WINDOW(50)) qmsw_device_i (.MCLK(mclk),
		.RST_N(rst_n), .LINK(link), .ACTIVE(active), .BUSY(busy),
		.QUAD_MODE(quad), .SINGLE_FALLBACK(fallback), .STATUS(status),
		.FLAGS(flags));
	qmsw_link_monitor qmsw_link_monitor_i (.MCLK(mclk), .RST_N(rst_n),
		.cs_n(link.cs_n), .wp_n(link.wp_n), .boost_high(link.boost_high),
		.dev_dq_oe(link.dev_dq_oe), .ACTIVE(active), .BUSY(busy),
		.QUAD_MODE(quad), .SINGLE_FALLBACK(fallback), .STATUS(status));
	task automatic summarize();
		$display("checked=%0d bad=%0d", samples_checked, bad_count);
		if (bad_count == 0 && samples_checked > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask
	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		samples_checked++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
		end
	endtask
	task automatic xfer(input logic w, input logic [7:0] a,
		input logic [31:0] d, output logic [31:0] q);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		adr <= a;
		wdat <= d;
		// Only the watchdog ends a wait for the answer
		do
			@(posedge mclk);
		while (ack !== 1'b1);
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
		@(posedge mclk);
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		logic [31:0] q;
		xfer(1'b1, a, d, q);
	endtask
	// Command word: auto latch, rx count, tx count, address, opcode
	task automatic frame(input logic [7:0] op, input logic ad,
		input logic [1:0] ntx, input logic [1:0] nrx, input logic au,
		input logic [15:0] tx, input logic [23:0] a);
		logic [31:0] q;
		int n;
		wr(HOST_ADDR_OFS, {8'h00, a});
		wr(HOST_TXD_OFS, {16'h0000, tx});
		wr(HOST_CMD_OFS, {18'h0, au, nrx, ntx, ad, op});
		n = 0;
		do begin
			xfer(1'b0, HOST_STAT_OFS, 32'h0, q);
			n++;
		end while (q[1:0] !== 2'b10 && n < 400);
		if (q[1:0] !== 2'b10)
			bad_count++;
		repeat (8) @(posedge mclk);
	endtask
	task automatic reg_rd(input logic [7:0] op, output logic [31:0] q);
		frame(op, 1'b0, 2'd0, 2'd1, 1'b0, 16'h0, 24'h0);
		xfer(1'b0, HOST_RXD_OFS, 32'h0, q);
	endtask
	task automatic reg_wr(input logic [7:0] op, input logic [7:0] d,
		input logic au);
		frame(op, 1'b0, 2'd1, 2'd0, au, {d, 8'h00}, 24'h0);
	endtask
	task automatic erase(input logic [7:0] op, input logic [23:0] a,
		input logic au);
		frame(op, 1'b1, 2'd0, 2'd0, au, 16'h0, a);
	endtask
	task automatic wait_idle();
		int n;
		n = 0;
		while (busy !== 1'b0 && n < 4000) begin
			@(posedge mclk);
			n++;
		end
		if (busy !== 1'b0)
			bad_count++;
		// Status image settles one cycle after busy drops
		repeat (2) @(posedge mclk);
	endtask
	task automatic soft_reset(input logic [31:0] ctrl);
		wr(HOST_CTRL_OFS, ctrl | 32'h10);
		repeat (12) @(posedge mclk);
		wr(HOST_CTRL_OFS, ctrl);
		repeat (8) @(posedge mclk);
	endtask
	task automatic t_reset();
		logic [31:0] q;
		check(status, SR_RESET);
		check(quad, 1'b0);
		xfer(1'b0, HOST_CTRL_OFS, 32'h0, q);
		check(q, CTRL_RESET);
		wr(8'h20, 32'hFFFF_FFFF);
		xfer(1'b0, 8'h20, 32'h0, q);
		check(q, 32'h0);
		reg_rd(STATUS_READ_CMD, q);
		check(q[7:0], SR_RESET);
	endtask
	task automatic t_protect();
		reg_wr(STATUS_WRITE_CMD, 8'h1C, 1'b0);
		check(status, 8'h00);
		reg_wr(STATUS_WRITE_CMD, 8'h1C, 1'b1);
		check(busy, 1'b1);
		wait_idle();
		check(status, 8'h1C);
		erase(WHOLE_ARRAY_ERASE_CMD, 24'h0, 1'b1);
		check(busy, 1'b0);
		check(status, 8'h1E);
		erase(BLOCK_ERASE_CMD, 24'hFF0000, 1'b1);
		check(busy, 1'b0);
		erase(BLOCK_ERASE_CMD, 24'h000000, 1'b1);
		check(busy, 1'b1);
		wait_idle();
		check(status, 8'h1C);
		reg_wr(STATUS_WRITE_CMD, 8'h3C, 1'b1);
		wait_idle();
		erase(BLOCK_ERASE_CMD, 24'h000000, 1'b1);
		check(busy, 1'b0);
		erase(BLOCK_ERASE_CMD, 24'hFF0000, 1'b1);
		check(busy, 1'b1);
		wait_idle();
	endtask
	task automatic t_lock();
		reg_wr(STATUS_WRITE_CMD, 8'hBC, 1'b1);
		wait_idle();
		wr(HOST_CTRL_OFS, 32'h0);
		reg_wr(STATUS_WRITE_CMD, 8'h00, 1'b1);
		check(busy, 1'b0);
		check(status, 8'hBE);
		wr(HOST_CTRL_OFS, 32'h04);
		reg_wr(STATUS_WRITE_CMD, 8'h00, 1'b1);
		wait_idle();
		check(status, 8'h00);
	endtask
	task automatic t_erase();
		erase(SMALL_BLOCK_ERASE_CMD, 24'h080000, 1'b1);
		check(busy, 1'b0);
		erase(SMALL_BLOCK_ERASE_CMD, 24'h070000, 1'b1);
		check(busy, 1'b1);
		wait_idle();
		erase(WHOLE_ARRAY_ERASE_CMD, 24'h0, 1'b0);
		check(busy, 1'b0);
		erase(WHOLE_ARRAY_ERASE_CMD, 24'h0, 1'b1);
		check(busy, 1'b1);
		wait_idle();
	endtask
	task automatic t_quad();
		logic [31:0] q;
		reg_wr(ENHANCED_CONFIG_WRITE_CMD, 8'h57, 1'b0);
		check(quad, 1'b1);
		wr(HOST_CTRL_OFS, 32'h07);
		reg_rd(ENHANCED_CONFIG_READ_CMD, q);
		check(q[7:0], 8'h57);
		reg_rd(VOLATILE_CONFIG_READ_CMD, q);
		check(q[7:0], VCFG_RESET);
		erase(BLOCK_ERASE_CMD, 24'h200000, 1'b1);
		reg_rd(STATUS_READ_CMD, q);
		check(q[7:0], 8'h03);
		wait_idle();
		wr(HOST_CTRL_OFS, 32'h0F);
		erase(BLOCK_ERASE_CMD, 24'h100000, 1'b1);
		check(fallback, 1'b1);
		reg_rd(STATUS_READ_CMD, q);
		check(q[7:0], 8'h03);
		wr(HOST_CTRL_OFS, 32'h07);
		repeat (12) @(posedge mclk);
		check(fallback, 1'b0);
		wait_idle();
		soft_reset(32'h07);
		check(quad, 1'b0);
		wr(HOST_CTRL_OFS, 32'h04);
	endtask
	task automatic t_late_boost();
		logic [31:0] q;
		reg_wr(ENHANCED_CONFIG_WRITE_CMD, 8'hD7, 1'b0);
		wr(HOST_CTRL_OFS, 32'h06);
		frame(PAGE_PROGRAM_CMD, 1'b1, 2'd1, 2'd0, 1'b1, 16'h5A00, 24'h300000);
		wait_idle();
		check(flags[FLAG_BOOST_ERR], 1'b1);
		reg_rd(FLAG_STATUS_READ_CMD, q);
		check(q[FLAG_BOOST_ERR], 1'b1);
		frame(FLAG_STATUS_CLEAR_CMD, 1'b0, 2'd0, 2'd0, 1'b0, 16'h0, 24'h0);
		check(flags[FLAG_BOOST_ERR], 1'b0);
	endtask
	task automatic t_boot_config();
		frame(WRITE_LATCH_SET_CMD, 1'b0, 2'd0, 2'd0, 1'b0, 16'h0, 24'h0);
		frame(NONVOLATILE_CONFIG_WRITE_CMD, 1'b0, 2'd2, 2'd0, 1'b0,
			16'hF7FF, 24'h0);
		wait_idle();
		check(quad, 1'b0);
		soft_reset(32'h04);
		check(quad, 1'b1);
	endtask
	initial begin
		repeat (16) @(posedge mclk);
		rst_n <= 1'b1;
		repeat (4) @(posedge mclk);
		t_reset();
		t_protect();
		t_lock();
		t_erase();
		t_quad();
		t_late_boost();
		t_boot_config();
		summarize();
	end
	// Whole sequence needs well under this many cycles
	initial begin
		repeat (90000) @(posedge mclk);
		bad_count++;
		summarize();
	end
endmodule
